//--- dcs_ddr2_command_sequencer.sv
// ddr2 command sequencer: init, refresh, paging, read and write bursts
// assumes requests held stable until req_ready_o, config inputs on clock_i
`include "dcs_params.svh"
`default_nettype none
module dcs_ddr2_command_sequencer
	import dcs_pkg::*;
#(
	parameter int          RR_W     = 13,
	parameter logic [12:0] EXT_MODE = `DCS_EMR_VALUE
) (
	input  wire logic            clock_i,
	input  wire logic            srst_i,
	input  wire logic            ce_i,
	input  wire logic [2:0]      cas_latency_i,
	input  wire logic [RR_W-1:0] refresh_rate_i,
	input  wire logic            req_valid_i,
	input  wire dcs_req_t        req_i,
	output logic                 req_ready_o,
	input  wire logic            self_refresh_req_i,
	input  wire logic            power_down_req_i,
	output logic                 init_done_o,
	output logic                 mem_clock_enable_o,
	output logic                 mem_chip_select_n_o,
	output logic                 row_strobe_n_o,
	output logic                 column_strobe_n_o,
	output logic                 mem_write_enable_n_o,
	output logic [2:0]           bank_addr_pins_o,
	output logic [13:0]          mem_addr_pins_o,
	output logic [3:0]           data_mask_n_o,
	output logic                 wr_data_en_o,
	output logic                 rd_data_valid_o
);
	localparam int TRCD_C = `DCS_CYC_UP(`DCS_TRCD_NS);
	localparam int TRP_C  = `DCS_CYC_UP(`DCS_TRP_NS);
	localparam int TRFC_C = `DCS_CYC_UP(`DCS_TRFC_NS);
	localparam int TXSR_C = `DCS_CYC_UP(`DCS_TXSR_NS);
	localparam int A10    = `DCS_ADDR_BIT_TEN;
	localparam logic [4:0] BL = 5'(`DCS_BURST_LEN);

	function automatic logic [7:0] wcount(input int n);
		wcount = 8'(n - 1);
	endfunction : wcount

	function automatic logic [2:0] clamp_cl(input logic [2:0] cl);
		clamp_cl = (cl < `DCS_CL_MIN) ? `DCS_CL_MIN : (cl > `DCS_CL_MAX) ? `DCS_CL_MAX : cl;
	endfunction : clamp_cl

	dcs_state_t      state_reg, state_next, ret_reg, ret_next;
	logic [7:0]      wait_reg, wait_next;
	dcs_cmd_t        cmd_next;
	logic [2:0]      ba_next;
	logic [13:0]     addr_next;
	logic            cke_next;
	logic            accept, inval_all, inval_bank, open_bank, ref_clr, boot_done;
	logic [7:0]      page_valid_reg;
	logic [13:0]     page_row_reg [8];
	logic [RR_W-1:0] ref_cnt_reg;
	logic            ref_pending_reg;
	logic            dp_act_reg, dp_write_reg;
	logic [4:0]      dp_time_reg;
	logic [2:0]      dp_lat_reg;
	logic [3:0]      dp_words_reg, dp_lanes_reg;

	// decoding of request, latency and data window
	wire logic [2:0]  cl       = clamp_cl(cas_latency_i);
	wire logic [12:0] mode_val = {6'h0, cl, 1'b0, `DCS_BL8_CODE};
	wire logic        hit      = page_valid_reg[req_i.bank] && page_row_reg[req_i.bank] == req_i.row;
	wire logic        conflict = page_valid_reg[req_i.bank] && !hit;
	wire logic        take     = req_valid_i && !req_ready_o && !dp_act_reg;
	wire logic        ref_tick = ref_cnt_reg >= (refresh_rate_i - RR_W'(1));
	wire logic [4:0]  dp_t1    = dp_time_reg + 5'h1;
	wire logic [4:0]  dp_beat  = dp_t1 - {2'h0, dp_lat_reg};
	wire logic        dp_win   = dp_act_reg && dp_t1 >= {2'h0, dp_lat_reg} && dp_beat < BL;
	wire logic        dp_want  = dp_beat < {1'b0, dp_words_reg};
	wire logic        dp_end   = dp_act_reg && dp_time_reg >= {2'h0, dp_lat_reg} + BL - 5'h1;
	wire logic        st_cmd   = state_reg == ST_RW;
	wire logic [2:0]  pin_cmd  = {row_strobe_n_o, column_strobe_n_o, mem_write_enable_n_o};

	always_comb
	begin
		state_next = state_reg;
		ret_next   = ret_reg;
		wait_next  = wait_reg;
		cmd_next   = cmd_nop;
		ba_next    = 3'h0;
		addr_next  = 14'h0;
		cke_next   = 1'b1;
		accept     = 1'b0;
		inval_all  = 1'b0;
		inval_bank = 1'b0;
		open_bank  = 1'b0;
		ref_clr    = 1'b0;
		boot_done  = 1'b0;
		case (state_reg)
			ST_BOOT_PALL, ST_INIT_PALL, ST_REF_PALL, ST_SR_PALL:
			begin
				if (state_reg == ST_BOOT_PALL && !mem_clock_enable_o)
					state_next = ST_BOOT_PALL; // cke rises with a nop first
				else
				begin
					cmd_next       = cmd_precharge_bank;
					addr_next[A10] = 1'b1;
					inval_all      = 1'b1;
					boot_done      = state_reg == ST_INIT_PALL;
					wait_next      = wcount(TRP_C);
					state_next     = ST_WAIT;
					ret_next       = (state_reg == ST_BOOT_PALL) ? ST_MRS :
					                 (state_reg == ST_INIT_PALL) ? ST_IDLE :
					                 (state_reg == ST_REF_PALL) ? ST_REF : ST_SR_ENTER;
				end
			end
			ST_MRS, ST_CMD_EXT_MODE_SET:
			begin
				cmd_next        = cmd_mode_set;
				ba_next[1:0]    = (state_reg == ST_MRS) ? `DCS_MR_SEL : `DCS_EMR_SEL;
				addr_next[12:0] = (state_reg == ST_MRS) ? mode_val : EXT_MODE;
				wait_next       = wcount(`DCS_TMRD_CYC);
				state_next      = ST_WAIT;
				ret_next        = (state_reg == ST_MRS) ? ST_CMD_EXT_MODE_SET : ST_INIT_PALL;
			end
			ST_IDLE:
			begin
				if (dp_act_reg)
					state_next = ST_IDLE;
				else if (ref_pending_reg)
					state_next = ST_REF_PALL;
				else if (self_refresh_req_i)
					state_next = ST_SR_PALL;
				else if (power_down_req_i)
					state_next = ST_PDN;
				else if (take)
					state_next = hit ? ST_RW : conflict ? ST_PRE_BANK : ST_ACT;
			end
			ST_REF:
			begin
				cmd_next   = cmd_autorefresh;
				inval_all  = 1'b1;
				ref_clr    = 1'b1;
				wait_next  = wcount(TRFC_C);
				state_next = ST_WAIT;
				ret_next   = ST_IDLE;
			end
			ST_SR_ENTER:
			begin
				cmd_next   = cmd_autorefresh;
				cke_next   = 1'b0;
				state_next = ST_SREF;
			end
			ST_SREF, ST_PDN:
			begin
				if ((state_reg == ST_SREF) ? self_refresh_req_i : (power_down_req_i && !ref_pending_reg))
					cke_next = 1'b0;
				else
				begin
					wait_next  = (state_reg == ST_SREF) ? wcount(TXSR_C) : wcount(`DCS_TXP_CYC);
					state_next = ST_WAIT;
					ret_next   = ST_IDLE;
				end
			end
			ST_PRE_BANK:
			begin
				cmd_next   = cmd_precharge_bank;
				ba_next    = req_i.bank;
				inval_bank = 1'b1;
				wait_next  = wcount(TRP_C);
				state_next = ST_WAIT;
				ret_next   = ST_ACT;
			end
			ST_ACT:
			begin
				cmd_next   = cmd_activate;
				ba_next    = req_i.bank;
				addr_next  = req_i.row;
				open_bank  = 1'b1;
				wait_next  = wcount(TRCD_C);
				state_next = ST_WAIT;
				ret_next   = ST_RW;
			end
			ST_RW:
			begin
				cmd_next        = req_i.write ? cmd_write_burst : cmd_read_burst;
				ba_next         = req_i.bank;
				addr_next[10:0] = req_i.col;
				accept          = 1'b1;
				state_next      = ST_IDLE;
			end
			ST_WAIT:
			begin
				if (wait_reg == 8'h0)
					state_next = ret_reg;
				else
					wait_next = wait_reg - 8'h1;
			end
			default:
				state_next = ST_BOOT_PALL;
		endcase
	end

	always_ff @(posedge clock_i)
	begin
		if (srst_i)
		begin
			state_reg <= ST_BOOT_PALL;
			ret_reg   <= ST_IDLE;
			wait_reg  <= 8'h0;
		end
		else if (ce_i)
		begin
			state_reg <= state_next;
			ret_reg   <= ret_next;
			wait_reg  <= wait_next;
		end
	end

	// command pins, always registered
	always_ff @(posedge clock_i)
	begin
		if (srst_i)
		begin
			{row_strobe_n_o, column_strobe_n_o, mem_write_enable_n_o} <= cmd_nop;
			bank_addr_pins_o    <= 3'h0;
			mem_addr_pins_o     <= 14'h0;
			mem_clock_enable_o  <= 1'b0;
			mem_chip_select_n_o <= 1'b0;
			req_ready_o         <= 1'b0;
			init_done_o         <= 1'b0;
		end
		else if (ce_i)
		begin
			{row_strobe_n_o, column_strobe_n_o, mem_write_enable_n_o} <= cmd_next;
			bank_addr_pins_o    <= ba_next;
			mem_addr_pins_o     <= addr_next;
			mem_clock_enable_o  <= cke_next;
			mem_chip_select_n_o <= 1'b0;
			req_ready_o         <= accept;
			init_done_o         <= init_done_o | boot_done;
		end
	end

	// open page table
	always_ff @(posedge clock_i)
	begin
		if (srst_i)
			page_valid_reg <= 8'h0;
		else if (ce_i)
		begin
			if (inval_all)
				page_valid_reg <= 8'h0;
			else if (inval_bank)
				page_valid_reg[req_i.bank] <= 1'b0;
			else if (open_bank)
				page_valid_reg[req_i.bank] <= 1'b1;
		end
	end

	always_ff @(posedge clock_i)
	begin
		if (ce_i && open_bank)
			page_row_reg[req_i.bank] <= req_i.row;
	end

	// refresh interval timer, no disable path; a tick beats a clear
	always_ff @(posedge clock_i)
	begin
		if (srst_i)
		begin
			ref_cnt_reg     <= '0;
			ref_pending_reg <= 1'b0;
		end
		else if (ce_i)
		begin
			ref_cnt_reg     <= ref_tick ? '0 : ref_cnt_reg + RR_W'(1);
			ref_pending_reg <= ref_tick | (ref_pending_reg & ~ref_clr);
		end
	end

	// data phase tracker for one burst
	always_ff @(posedge clock_i)
	begin
		if (srst_i)
		begin
			dp_act_reg   <= 1'b0;
			dp_write_reg <= 1'b0;
			dp_time_reg  <= 5'h0;
			dp_lat_reg   <= 3'h2;
			dp_words_reg <= 4'h0;
			dp_lanes_reg <= 4'h0;
		end
		else if (ce_i)
		begin
			if (st_cmd)
			begin
				dp_act_reg   <= 1'b1;
				dp_write_reg <= req_i.write;
				dp_time_reg  <= 5'h0;
				dp_lat_reg   <= req_i.write ? cl - 3'h1 : cl;
				dp_words_reg <= req_i.words;
				dp_lanes_reg <= req_i.lane_en;
			end
			else if (dp_end)
				dp_act_reg <= 1'b0;
			else if (dp_act_reg)
				dp_time_reg <= dp_t1;
		end
	end

	always_ff @(posedge clock_i)
	begin
		if (srst_i)
		begin
			wr_data_en_o    <= 1'b0;
			rd_data_valid_o <= 1'b0;
			data_mask_n_o   <= 4'h0;
		end
		else if (ce_i)
		begin
			wr_data_en_o    <= dp_win && dp_write_reg;
			rd_data_valid_o <= dp_win && !dp_write_reg && dp_want;
			data_mask_n_o   <= (dp_win && dp_write_reg && dp_want) ? dp_lanes_reg : 4'h0;
		end
	end

	// helpers watched only by assertions
	logic       last_pall_reg;
	logic [4:0] since_act_reg;
	always_ff @(posedge clock_i)
	begin
		if (srst_i)
		begin
			last_pall_reg <= 1'b0;
			since_act_reg <= 5'h0;
		end
		else if (ce_i)
		begin
			if (pin_cmd != cmd_nop)
				last_pall_reg <= pin_cmd == cmd_precharge_bank && mem_addr_pins_o[A10];
			if (pin_cmd == cmd_activate)
				since_act_reg <= 5'h1;
			else if (since_act_reg != 5'h1f)
				since_act_reg <= since_act_reg + 5'h1;
		end
	end

	sequence s_wr_burst;
		wr_data_en_o [*8] ##1 !wr_data_en_o;
	endsequence

	sequence s_rw_on_pins;
		pin_cmd == cmd_read_burst || pin_cmd == cmd_write_burst;
	endsequence

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (srst_i || !ce_i);

	AST_CS_LOW: assert property (!mem_chip_select_n_o)
		else $error("chip select left low state");
	AST_REF_AFTER_PALL: assert property (pin_cmd == cmd_autorefresh |-> last_pall_reg)
		else $error("refresh without preceding precharge all");
	AST_RCD: assert property (s_rw_on_pins |-> since_act_reg >= 5'(TRCD_C))
		else $error("access too soon after activate");
	AST_MODE_INIT: assert property (pin_cmd == cmd_mode_set |-> !init_done_o)
		else $error("mode load after initialization");
	AST_CKE_FALL: assert property ($fell(mem_clock_enable_o) |->
		pin_cmd == cmd_autorefresh || pin_cmd == cmd_nop)
		else $error("bad command at clock enable fall");
	AST_CKE_RISE: assert property ($rose(mem_clock_enable_o) |-> pin_cmd == cmd_nop)
		else $error("bad command at clock enable rise");
	AST_WR_BURST: assert property ($rose(wr_data_en_o) |-> s_wr_burst)
		else $error("write burst not eight beats");
	AST_WR_LAT: assert property (pin_cmd == cmd_write_burst && cl == 3'h3 |->
		!wr_data_en_o [*2] ##1 wr_data_en_o)
		else $error("write data latency wrong");
	AST_RD_LAT: assert property (pin_cmd == cmd_read_burst && cl == 3'h3 && req_i.words != 4'h0 |->
		!rd_data_valid_o [*3] ##1 rd_data_valid_o)
		else $error("read data latency wrong");
	AST_A10_BANK: assert property (pin_cmd == cmd_precharge_bank && $past(state_reg) == ST_PRE_BANK
		|-> !mem_addr_pins_o[A10])
		else $error("bank precharge with address bit ten high");
	AST_OPEN_ROW: assert property (pin_cmd == cmd_activate |-> page_valid_reg[bank_addr_pins_o])
		else $error("activated bank not marked open");
endmodule : dcs_ddr2_command_sequencer
`default_nettype wire

//--- dcs_params.svh
// timing counts, pin encodings and fixed values of the ddr2 command sequencer
// assumes a 125 mhz controller clock and one command slot per cycle
// Summary of operation
// - encode commands on row, column, write strobes
// - cke low enters, cke high exits low power
// - mode loads: bank selects register, address carries data
// - mode loads only during initialization
// - precharge all precedes every autorefresh
// - autorefresh at programmed refresh rate
// - pages invalid around every autorefresh
// - autorefresh can never be disabled
// - activate closed row with bank and row
// - wait row-to-column delay after activate
// - precharge all after reset and initialization
// - precharge all before refresh and mode loads
// - precharge all drives address bit ten high
// - bank precharge drives address bit ten low
// - read: column low, column and bank on pins
// - burst of eight, cas latency two to five
// - zero additive latency, read data at cas
// - surplus read beats are discarded
// - rows stay open until page invalid
// - write data starts cas latency minus one
// - every write burst of eight, lanes masked
// - short writes mask remaining beats
// - chip select held low always
`ifndef DCS_PARAMS_SVH
`define DCS_PARAMS_SVH
`define DCS_CLK_MHZ 125
`define DCS_CYC_UP(ns) ((((ns) * `DCS_CLK_MHZ) + 999) / 1000)
`define DCS_TRCD_NS 15
`define DCS_TRP_NS 15
`define DCS_TRFC_NS 128
`define DCS_TXSR_NS 200
`define DCS_TMRD_CYC 2
`define DCS_TXP_CYC 3
`define DCS_BURST_LEN 8
`define DCS_ADDR_BIT_TEN 10
`define DCS_MR_SEL 2'h0
`define DCS_EMR_SEL 2'h1
`define DCS_BL8_CODE 3'h3
`define DCS_EMR_VALUE 13'h0000
`define DCS_CL_MIN 3'h2
`define DCS_CL_MAX 3'h5
`endif

//--- dcs_pkg.sv
// types of the ddr2 command sequencer
// command and state encodings fixed here; timing values in dcs_params.svh
`default_nettype none
package dcs_pkg;
	typedef enum logic [2:0] {
		cmd_mode_set       = 3'h0,
		cmd_autorefresh    = 3'h1,
		cmd_precharge_bank = 3'h2,
		cmd_activate       = 3'h3,
		cmd_write_burst    = 3'h4,
		cmd_read_burst     = 3'h5,
		cmd_nop            = 3'h7
	} dcs_cmd_t;
	typedef enum logic [3:0] {
		ST_BOOT_PALL = 4'h0, ST_MRS = 4'h1, ST_CMD_EXT_MODE_SET = 4'h2, ST_INIT_PALL = 4'h3,
		ST_IDLE = 4'h4, ST_REF_PALL = 4'h5, ST_REF = 4'h6, ST_SR_PALL = 4'h7,
		ST_SR_ENTER = 4'h8, ST_SREF = 4'h9, ST_PDN = 4'ha, ST_PRE_BANK = 4'hb,
		ST_ACT = 4'hc, ST_RW = 4'hd, ST_WAIT = 4'he
	} dcs_state_t;
	typedef struct packed {
		logic        write;
		logic [2:0]  bank;
		logic [13:0] row;
		logic [10:0] col;
		logic [3:0]  words;
		logic [3:0]  lane_en;
	} dcs_req_t;
endpackage : dcs_pkg
`default_nettype wire

//--- dcs_mem_model.sv
// far-side ddr2 memory model: tracks open banks, counts protocol slips
// assumes pins sampled on the controller clock rising edge
`default_nettype none
module dcs_mem_model
	import dcs_pkg::*;
(
	input  wire logic        clock_i,
	input  wire logic        srst_i,
	input  wire logic        cke_i,
	input  wire logic [2:0]  cmd_i,
	input  wire logic [2:0]  bank_i,
	input  wire logic [13:0] addr_i,
	output logic [7:0]       err_cnt_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] open_reg;
	logic       cke_reg;
	int         since_act [8];
	always @(posedge clock_i)
	begin
		cke_reg <= cke_i;
		for (int i = 0; i < 8; i++)
			since_act[i] <= since_act[i] + 1;
		if (srst_i)
		begin
			open_reg  <= 8'h00;
			err_cnt_o <= 8'h00;
			for (int i = 0; i < 8; i++)
				since_act[i] <= 16;
		end
		else if (cke_reg)
		begin
			case (cmd_i)
				cmd_activate:
				begin
					if (open_reg[bank_i]) err_cnt_o <= err_cnt_o + 8'h01;
					open_reg[bank_i]  <= 1'b1;
					since_act[bank_i] <= 1;
				end
				cmd_precharge_bank:
				begin
					if (addr_i[10]) open_reg <= 8'h00;
					else open_reg[bank_i] <= 1'b0;
				end
				cmd_mode_set, cmd_autorefresh:
				begin
					if (|open_reg) err_cnt_o <= err_cnt_o + 8'h01;
				end
				cmd_read_burst, cmd_write_burst:
				begin
					if (!open_reg[bank_i] || since_act[bank_i] < 2)
						err_cnt_o <= err_cnt_o + 8'h01;
				end
				default: ;
			endcase
		end
	end
endmodule : dcs_mem_model
`default_nettype wire

//--- tb_ddr2_command_sequencer.sv
// self-checking bench of the ddr2 command sequencer with a memory model
// assumes 125 mhz clock, inputs driven on the falling edge
`default_nettype none
module tb_ddr2_command_sequencer;
	import dcs_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clock_i, srst, req_valid, sr_req, pd_req, req_ready, init_done;
	logic        cke, cs_n, ras, cas, we, wr_en, rd_valid;
	logic [2:0]  cl, bank;
	logic [12:0] rate;
	logic [13:0] addr;
	logic [3:0]  mask;
	logic [7:0]  err_cnt;
	dcs_req_t    req;
	wire  [2:0]  cmd = {ras, cas, we};
	int          fails, n_compared;
	dcs_ddr2_command_sequencer i_dut (.clock_i(clock_i), .srst_i(srst), .ce_i(1'b1),
		.cas_latency_i(cl), .refresh_rate_i(rate), .req_valid_i(req_valid), .req_i(req),
		.req_ready_o(req_ready), .self_refresh_req_i(sr_req), .power_down_req_i(pd_req),
		.init_done_o(init_done), .mem_clock_enable_o(cke), .mem_chip_select_n_o(cs_n),
		.row_strobe_n_o(ras), .column_strobe_n_o(cas), .mem_write_enable_n_o(we),
		.bank_addr_pins_o(bank), .mem_addr_pins_o(addr), .data_mask_n_o(mask),
		.wr_data_en_o(wr_en), .rd_data_valid_o(rd_valid));
	dcs_mem_model i_mem (.clock_i(clock_i), .srst_i(srst), .cke_i(cke), .cmd_i(cmd),
		.bank_i(bank), .addr_i(addr), .err_cnt_o(err_cnt));
	always #4 clock_i = ~clock_i;
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		n_compared++;
		if (g !== e)
		begin
			fails++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic give_verdict();
		$display("compared %0d, mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : give_verdict
	task automatic wait_cmd(input logic [2:0] c, output logic [2:0] p, output int k);
		p = 3'h7;
		for (k = 0; k < 400 && cmd !== c; k++)
		begin
			if (cmd !== 3'h7) p = cmd;
			@(negedge clock_i);
		end
		chk("command seen", c, cmd);
	endtask : wait_cmd
	task automatic wait_cke(input logic v);
		for (int k = 0; k < 100 && cke !== v; k++)
			@(negedge clock_i);
		chk("clock enable", v, cke);
	endtask : wait_cke
	task automatic init_chk();
		logic [2:0] p;
		int         n;
		wait_cmd(cmd_precharge_bank, p, n);
		chk("reset pall a10", 1'b1, addr[10]);
		wait_cmd(cmd_mode_set, p, n);
		chk("mode after pall", cmd_precharge_bank, p);
		chk("mode bank", 3'h0, bank);
		chk("mode value", {6'h0, cl, 1'b0, 3'h3}, addr[12:0]);
		@(negedge clock_i);
		wait_cmd(cmd_mode_set, p, n);
		chk("ext mode bank", 3'h1, bank);
		chk("ext mode value", 13'h0000, addr[12:0]);
		@(negedge clock_i);
		wait_cmd(cmd_precharge_bank, p, n);
		chk("init pall a10", 1'b1, addr[10]);
		wait_cke(1'b1);
		for (int k = 0; k < 20 && init_done !== 1'b1; k++)
			@(negedge clock_i);
		chk("init done", 1'b1, init_done);
	endtask : init_chk
	task automatic access(input logic w, input logic [2:0] b, input logic [13:0] r,
		input logic [9:0] c, input logic [3:0] n, input int nexp);
		int t, tact, first, cnt, ncmd;
		req = '{w, b, r, {1'b0, c}, n, 4'h5};
		req_valid = 1'b1;
		{tact, first, cnt, ncmd} = '0;
		for (t = 0; t < 60 && req_ready !== 1'b1; t++)
		begin
			@(negedge clock_i);
			if (cmd !== 3'h7) ncmd++;
			if (cmd === cmd_precharge_bank)
			begin
				chk("bank pall a10", 1'b0, addr[10]);
				chk("bank pall bank", b, bank);
			end
			if (cmd === cmd_activate)
			begin
				chk("activate row", r, addr);
				chk("activate bank", b, bank);
				tact = t;
			end
		end
		req_valid = 1'b0;
		chk("access command", w ? cmd_write_burst : cmd_read_burst, cmd);
		chk("column", c, addr[9:0]);
		chk("column a10", 1'b0, addr[10]);
		chk("access bank", b, bank);
		chk("commands issued", nexp, ncmd);
		if (nexp > 1) chk("rcd gap", 1'b1, t - 1 - tact >= 2);
		for (int k = 1; k < 16; k++)
		begin
			@(negedge clock_i);
			if (w ? wr_en : rd_valid)
			begin
				if (w) chk("write mask", cnt < n ? 4'h5 : 4'h0, mask);
				if (first == 0) first = k;
				cnt++;
			end
		end
		if (w) chk("write beats", 8, cnt);
		if (w) chk("write start", cl - 3'h1, first);
		if (!w) chk("read beats", n, cnt);
		if (!w) chk("read start", cl, first);
	endtask : access
	task automatic refresh_test();
		logic [2:0] p;
		int         n;
		rate = 13'h0040;
		wait_cmd(cmd_autorefresh, p, n);
		chk("pall before refresh", cmd_precharge_bank, p);
		@(negedge clock_i);
		wait_cmd(cmd_autorefresh, p, n);
		chk("refresh interval", 64, n + 1);
		rate = 13'h1fff;
		@(negedge clock_i);
		access(0, 3'h2, 14'h0009, 10'h020, 4'h8, 2);
		$display("done: refresh");
	endtask : refresh_test
	task automatic low_power_test();
		logic [2:0] p;
		int         n;
		sr_req = 1'b1;
		wait_cmd(cmd_autorefresh, p, n);
		chk("self refresh cke", 1'b0, cke);
		chk("pall before self refresh", cmd_precharge_bank, p);
		repeat (5) @(negedge clock_i);
		chk("self refresh held", 1'b0, cke);
		sr_req = 1'b0;
		wait_cke(1'b1);
		chk("self refresh exit nop", 3'h7, cmd);
		repeat (40) @(negedge clock_i);
		pd_req = 1'b1;
		wait_cke(1'b0);
		chk("power down nop", 3'h7, cmd);
		repeat (5) @(negedge clock_i);
		pd_req = 1'b0;
		wait_cke(1'b1);
		chk("power down exit nop", 3'h7, cmd);
		$display("done: low power");
	endtask : low_power_test
	always @(negedge clock_i)
		if (!srst)
		begin
			chk("chip select", 1'b0, cs_n);
			if (init_done === 1'b1 && cmd === cmd_mode_set) chk("mode in run", 0, 1);
		end
	initial
	begin
		#200000;
		fails++;
		$display("Error watchdog expected finish seen timeout");
		give_verdict();
	end
	initial
	begin
		{clock_i, req_valid, sr_req, pd_req} = '0;
		{srst, cl, rate, req} = {1'b1, 3'h2, 13'h1fff, 37'h0};
		for (int c = 2; c <= 5; c++)
		begin
			cl = 3'(c);
			srst = 1'b1;
			repeat (3) @(negedge clock_i);
			srst = 1'b0;
			init_chk();
			access(1, 3'h2, 14'h0005, 10'h008, 4'h3, 2);
			access(0, 3'h2, 14'h0005, 10'h010, 4'h5, 1);
			$display("done: cas latency %0d", c);
		end
		access(0, 3'h2, 14'h0009, 10'h018, 4'h8, 3);
		access(1, 3'h2, 14'h0005, 10'h000, 4'h1, 3);
		$display("done: row conflict");
		refresh_test();
		low_power_test();
		chk("memory model slips", 8'h00, err_cnt);
		give_verdict();
	end
endmodule : tb_ddr2_command_sequencer
`default_nettype wire
